// file: verilog/tst_target.sv
// Two-wire target port of the temperature sensor
//
// Implementation choices: the register addresses and register access over the register_index, rd_data and wr_en port.
`timescale 1ns/1ps
`default_nettype none
module tst_target
   import tst_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC,
   parameter int RELOAD_CYCLES = RELOAD_CYC
) (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, active low
   tst_link_if.tgt link, // Two-wire bus
   input wire logic address_select_pin, // Strap pin level
   input wire logic alert_active, // Alert output is asserted
   input wire logic alert_high, // Alert cause is high limit
   input wire logic threshold_or_window_select, // 1: threshold mode
   input wire logic [15:0] rd_data, // Word at register_index
   output logic [7:0] register_index, // Selected register
   output logic wr_en, // Word write strobe
   output logic [15:0] wr_data, // Word to write
   output logic alert_clear, // Won alert reply with threshold_or_window_select low, drop alert
   output logic soft_reset, // General-call reset pulse
   output logic reloading // Registers reloading
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_RX = 6'b000010,
      ST_RACK = 6'b000100,
      ST_TX = 6'b001000,
      ST_TACK = 6'b010000,
      ST_WAIT = 6'b100000
   } tst_tgt_st_t;

   localparam int TOW = $clog2(TIMEOUT_CYCLES + 1);
   localparam int RLW = $clog2(RELOAD_CYCLES + 1);

   tst_tgt_st_t state_q;
   logic [2:0] meta_q, sync_q, prev_q;
   logic scl_s, sda_s, pin_s, scl_p, sda_p;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic lo_seen_q, hi_seen_q, diff_sda_q;
   logic [1:0] sel;
   logic [6:0] own_addr;
   logic [3:0] cnt_q;
   logic [7:0] sh_q, tx_q, wr_hi_q;
   logic [15:0] word_q;
   logic sda_oe_q, got_addr_q, rd_q, ara_q, gc_q, has_idx_q, wlsb_q, rlsb_q, nack_q;
   logic busy_q, timeout;
   logic [TOW-1:0] to_cnt_q;
   logic [RLW-1:0] rl_cnt_q;

   // Two-stage synchronisers, then one history stage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_q <= 3'h7;
         sync_q <= 3'h7;
         prev_q <= 3'h7;
      end else begin
         meta_q <= {address_select_pin, link.sda, link.scl};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign {pin_s, sda_s, scl_s} = sync_q;
   assign {sda_p, scl_p} = prev_q[1:0];
   assign scl_rise = scl_s & ~scl_p;
   assign scl_fall = ~scl_s & scl_p;
   assign start_det = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_det = scl_s & scl_p & ~sda_p & sda_s;

   // Strap decode, idle during reload so the reset fill never counts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lo_seen_q <= 1'b0;
         hi_seen_q <= 1'b0;
         diff_sda_q <= 1'b0;
      end else if (sync_q == prev_q && !reloading) begin
         lo_seen_q <= lo_seen_q | ~pin_s;
         hi_seen_q <= hi_seen_q | pin_s;
         diff_sda_q <= diff_sda_q | (pin_s ^ sda_s);
      end
   end

   assign sel = (lo_seen_q && hi_seen_q) ? {1'b1, diff_sda_q} : {1'b0, hi_seen_q};
   assign own_addr = {ADDR_HI, sel};

   // Bus timeout while a transfer is open
   assign timeout = busy_q && (32'(to_cnt_q) == TIMEOUT_CYCLES - 1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_q <= 1'b0;
         to_cnt_q <= '0;
      end else begin
         if (start_det) busy_q <= 1'b1;
         else if (stop_det || timeout) busy_q <= 1'b0;
         if (!busy_q || start_det || (scl_s && !(sda_oe_q && !sda_s))) to_cnt_q <= '0;
         else to_cnt_q <= to_cnt_q + 1'b1;
      end
   end

   // Reload window after reset or general-call reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) rl_cnt_q <= RLW'(RELOAD_CYCLES);
      else if (soft_reset) rl_cnt_q <= RLW'(RELOAD_CYCLES);
      else if (rl_cnt_q != '0) rl_cnt_q <= rl_cnt_q - 1'b1;
   end
   assign reloading = (rl_cnt_q != '0);

   // Byte engine
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         tx_q <= 8'h00;
         wr_hi_q <= 8'h00;
         word_q <= 16'h0000;
         sda_oe_q <= 1'b0;
         {got_addr_q, rd_q, ara_q, gc_q, has_idx_q, wlsb_q, rlsb_q, nack_q} <= 8'h00;
         register_index <= INDEX_RESET;
         wr_en <= 1'b0;
         wr_data <= 16'h0000;
         alert_clear <= 1'b0;
         soft_reset <= 1'b0;
      end else begin
         wr_en <= 1'b0;
         alert_clear <= 1'b0;
         soft_reset <= 1'b0;
         if (soft_reset) register_index <= INDEX_RESET;
         if (timeout) begin
            state_q <= ST_WAIT;
         end else if (start_det) begin
            state_q <= ST_RX;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
            {got_addr_q, rd_q, ara_q, gc_q, has_idx_q, wlsb_q} <= 6'h00;
         end else if (stop_det) begin
            state_q <= ST_IDLE;
            sda_oe_q <= 1'b0;
         end else begin
            unique case (state_q)
               ST_IDLE: begin
                  sda_oe_q <= 1'b0;
               end
               ST_WAIT: begin
                  if (!scl_s) sda_oe_q <= 1'b0;
               end
               ST_RX: begin
                  if (scl_rise) begin
                     sh_q <= {sh_q[6:0], sda_s};
                     cnt_q <= cnt_q + 4'h1;
                  end else if (scl_fall && cnt_q == 4'h8) begin
                     cnt_q <= 4'h0;
                     state_q <= ST_RACK;
                     sda_oe_q <= 1'b1;
                     if (!got_addr_q) begin
                        got_addr_q <= 1'b1;
                        rd_q <= sh_q[0];
                        if (sh_q[7:1] == own_addr) begin
                           ara_q <= 1'b0;
                        end else if (sh_q == GC_BYTE) begin
                           gc_q <= 1'b1;
                        end else if (sh_q == ARA_BYTE && alert_active) begin
                           ara_q <= 1'b1;
                        end else begin
                           state_q <= ST_WAIT;
                           sda_oe_q <= 1'b0;
                        end
                     end else if (gc_q) begin
                        if (sh_q == GC_RESET_CMD) begin
                           soft_reset <= 1'b1;
                        end else begin
                           state_q <= ST_WAIT;
                           sda_oe_q <= 1'b0;
                        end
                     end else if (!has_idx_q) begin
                        has_idx_q <= 1'b1;
                        register_index <= sh_q;
                     end else if (!wlsb_q) begin
                        wr_hi_q <= sh_q;
                        wlsb_q <= 1'b1;
                     end else begin
                        wlsb_q <= 1'b0;
                        wr_data <= {wr_hi_q, sh_q};
                        wr_en <= ~reloading;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_fall) begin
                     if (ara_q) begin
                        tx_q <= {own_addr, alert_high};
                        sda_oe_q <= ~own_addr[6];
                        state_q <= ST_TX;
                     end else if (rd_q && !gc_q) begin
                        word_q <= rd_data;
                        tx_q <= rd_data[15:8];
                        sda_oe_q <= ~rd_data[15];
                        rlsb_q <= 1'b1;
                        state_q <= ST_TX;
                     end else begin
                        sda_oe_q <= 1'b0;
                        state_q <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_rise && ara_q && !sda_oe_q && !sda_s) begin
                     state_q <= ST_WAIT;
                  end else if (scl_fall) begin
                     if (cnt_q == 4'h7) begin
                        cnt_q <= 4'h0;
                        sda_oe_q <= 1'b0;
                        state_q <= ST_TACK;
                     end else begin
                        cnt_q <= cnt_q + 4'h1;
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe_q <= ~tx_q[6];
                     end
                  end
               end
               ST_TACK: begin
                  if (scl_rise) begin
                     nack_q <= sda_s;
                  end else if (scl_fall) begin
                     if (ara_q) begin
                        alert_clear <= ~threshold_or_window_select;
                        state_q <= ST_WAIT;
                     end else if (nack_q) begin
                        state_q <= ST_WAIT;
                     end else if (rlsb_q) begin
                        tx_q <= word_q[7:0];
                        sda_oe_q <= ~word_q[7];
                        rlsb_q <= 1'b0;
                        state_q <= ST_TX;
                     end else begin
                        word_q <= rd_data;
                        tx_q <= rd_data[15:8];
                        sda_oe_q <= ~rd_data[15];
                        rlsb_q <= 1'b1;
                        state_q <= ST_TX;
                     end
                  end
               end
               default: begin
                  state_q <= ST_IDLE;
                  sda_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

   assign link.t_sda_oe = sda_oe_q;
endmodule
`default_nettype wire

// file: verilog/tst_pkg.sv
// Shared constants for the two-wire sensor target and its bus controller
package tst_pkg;
   localparam int CLK_HZ = 250_000_000;
   // Target addressing
   localparam logic [4:0] ADDR_HI = 5'h12;
   localparam logic [7:0] ARA_BYTE = 8'h19;
   localparam logic [7:0] GC_BYTE = 8'h00;
   localparam logic [7:0] GC_RESET_CMD = 8'h06;
   localparam logic [7:0] INDEX_RESET = 8'h00;
   // Timing
   localparam int TIMEOUT_MS = 35;
   localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int RELOAD_US = 1500;
   localparam int RELOAD_CYC = RELOAD_US * (CLK_HZ / 1_000_000);
   localparam int SCL_HZ = 400_000;
   localparam int SCL_QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
   // Controller register map (byte offsets)
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] TXD_OFS = 8'h04;
   localparam logic [7:0] RXD_OFS = 8'h08;
   localparam logic [7:0] STAT_OFS = 8'h0c;
   // CTRL fields
   localparam int CTRL_ADDR_LSB = 0;
   localparam int CTRL_RW_BIT = 0;
   localparam int CTRL_NB_LSB = 8;
   // STAT fields
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
endpackage

// file: verilog/tst_link_if.sv
// Open-drain two-wire link joining controller and target
`timescale 1ns/1ps
`default_nettype none
interface tst_link_if;
   logic m_scl_oe; // Controller pulls clock low
   logic m_sda_oe; // Controller pulls data low
   logic t_sda_oe; // Target pulls data low
   logic scl;
   logic sda;
   assign scl = ~m_scl_oe;
   assign sda = ~(m_sda_oe | t_sda_oe);
   modport ctrl (output m_scl_oe, output m_sda_oe, input scl, input sda);
   modport tgt (output t_sda_oe, input scl, input sda);
endinterface
`default_nettype wire

// file: verilog/tst_controller.sv
// Two-wire bus controller with an AHB-Lite register port
`timescale 1ns/1ps
`default_nettype none
module tst_controller
   import tst_pkg::*;
#(
   parameter int QTR_CYCLES = SCL_QTR_CYC
) (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write access
   input wire logic [2:0] hsize, // Transfer size, word only
   input wire logic hready, // Bus ready
   input wire logic [31:0] hwdata, // Write data
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Always ready
   output logic hresp, // Always OKAY
   tst_link_if.ctrl link // Two-wire bus
);
   typedef enum logic [3:0] {
      CS_IDLE = 4'b0001,
      CS_START = 4'b0010,
      CS_XFER = 4'b0100,
      CS_STOP = 4'b1000
   } tst_ctl_st_t;

   localparam int QW = $clog2(QTR_CYCLES + 1);

   tst_ctl_st_t state_q;
   logic ap_wr_q;
   logic [7:0] ap_addr_q;
   logic [31:0] ctrl_q, txd_q, rxd_q, txsh_q;
   logic busy_q, nack_q, rw_q, is_addr_q;
   logic [2:0] left_q;
   logic [QW-1:0] div_q;
   logic tick;
   logic [1:0] qtr_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic scl_oe_q, sda_oe_q;
   logic [1:0] sda_meta_q;
   logic sda_s, sending;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // AHB-Lite address phase capture and registered read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_q <= 1'b0;
         ap_addr_q <= 8'h00;
         hrdata <= REG_RESET;
      end else begin
         ap_wr_q <= hsel & htrans[1] & hready & hwrite;
         ap_addr_q <= haddr[7:0];
         hrdata <= REG_RESET;
         if (hsel && htrans[1] && hready && !hwrite) begin
            unique case (haddr[7:0])
               CTRL_OFS: hrdata <= ctrl_q;
               TXD_OFS: hrdata <= txd_q;
               RXD_OFS: hrdata <= rxd_q;
               STAT_OFS: hrdata <= {30'h0, nack_q, busy_q};
               default: hrdata <= REG_RESET;
            endcase
         end
      end
   end

   // Data input synchroniser
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) sda_meta_q <= 2'b11;
      else sda_meta_q <= {sda_meta_q[0], link.sda};
   end
   assign sda_s = sda_meta_q[1];

   // Quarter-period divider for the generated clock
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) div_q <= '0;
      else if (state_q == CS_IDLE || 32'(div_q) == QTR_CYCLES - 1) div_q <= '0;
      else div_q <= div_q + 1'b1;
   end
   assign tick = (state_q != CS_IDLE) && (32'(div_q) == QTR_CYCLES - 1);
   assign sending = is_addr_q | ~rw_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= CS_IDLE;
         ctrl_q <= REG_RESET;
         txd_q <= REG_RESET;
         rxd_q <= REG_RESET;
         txsh_q <= REG_RESET;
         {busy_q, nack_q, rw_q, is_addr_q} <= 4'h0;
         left_q <= 3'h0;
         qtr_q <= 2'h0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         if (ap_wr_q && ap_addr_q == TXD_OFS) txd_q <= hwdata;
         if (ap_wr_q && ap_addr_q == CTRL_OFS && !busy_q) begin
            ctrl_q <= hwdata;
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            rw_q <= hwdata[CTRL_RW_BIT];
            sh_q <= hwdata[CTRL_ADDR_LSB +: 8];
            left_q <= hwdata[CTRL_NB_LSB +: 3];
            txsh_q <= (ap_addr_q == TXD_OFS) ? hwdata : txd_q;
            is_addr_q <= 1'b1;
            qtr_q <= 2'h0;
            bit_q <= 4'h0;
            state_q <= CS_START;
         end else if (tick) begin
            qtr_q <= qtr_q + 2'h1;
            unique case (state_q)
               CS_START: begin
                  if (qtr_q == 2'h0) sda_oe_q <= 1'b1;
                  if (qtr_q == 2'h1) begin
                     scl_oe_q <= 1'b1;
                     qtr_q <= 2'h0;
                     state_q <= CS_XFER;
                  end
               end
               CS_XFER: begin
                  unique case (qtr_q)
                     2'h0: begin
                        if (bit_q != 4'h8) sda_oe_q <= sending & ~sh_q[7];
                        else sda_oe_q <= ~sending & (left_q > 3'h1);
                     end
                     2'h1: scl_oe_q <= 1'b0;
                     2'h2: begin
                        if (bit_q != 4'h8) sh_q <= {sh_q[6:0], sda_s};
                        else if (sending) nack_q <= sda_s;
                        else rxd_q <= {rxd_q[23:0], sh_q};
                     end
                     2'h3: begin
                        scl_oe_q <= 1'b1;
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h8) begin
                           bit_q <= 4'h0;
                           if (!is_addr_q) left_q <= left_q - 3'h1;
                           is_addr_q <= 1'b0;
                           if (nack_q || left_q == 3'h0 || (!is_addr_q && left_q == 3'h1)) begin
                              state_q <= CS_STOP;
                           end else if (!rw_q) begin
                              sh_q <= txsh_q[31:24];
                              txsh_q <= {txsh_q[23:0], 8'h00};
                           end
                        end
                     end
                     default: scl_oe_q <= 1'b1;
                  endcase
               end
               CS_STOP: begin
                  if (qtr_q == 2'h0) sda_oe_q <= 1'b1;
                  if (qtr_q == 2'h1) scl_oe_q <= 1'b0;
                  if (qtr_q == 2'h2) sda_oe_q <= 1'b0;
                  if (qtr_q == 2'h3) begin
                     busy_q <= 1'b0;
                     state_q <= CS_IDLE;
                  end
               end
               default: state_q <= CS_IDLE;
            endcase
         end
      end
   end

   assign link.m_scl_oe = scl_oe_q;
   assign link.m_sda_oe = sda_oe_q;
endmodule
`default_nettype wire

// file: tb/tst_link_props.sv
// Wire-level checks on the two-wire link
`timescale 1ns/1ps
`default_nettype none
module tst_link_props
   import tst_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = 2000
) (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, active low
   input wire logic m_scl_oe, // Controller clock pull
   input wire logic m_sda_oe, // Controller data pull
   input wire logic t_sda_oe, // Target data pull
   input wire logic scl, // Clock wire
   input wire logic sda // Data wire
);
   logic scl_q, sda_q, frame_q, done_q;
   logic [3:0] bit_q;
   logic [7:0] byte_q, sh_q, addr_q;
   int low_q;
   wire rise = scl & ~scl_q;
   wire start = scl & scl_q & sda_q & ~sda;
   wire stop = scl & scl_q & ~sda_q & sda;
   wire foreign = addr_q[7:3] != ADDR_HI && addr_q[7:1] != 7'h00 && addr_q != ARA_BYTE;
   wire past_addr = byte_q != 8'h00 || bit_q == 4'h8;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         low_q <= 0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         low_q <= t_sda_oe ? low_q + 1 : 0;
      end
   end
   // Bit and byte position within the current frame
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         frame_q <= 1'b0;
         done_q <= 1'b0;
         bit_q <= 4'h0;
         byte_q <= 8'h00;
         sh_q <= 8'h00;
         addr_q <= 8'h00;
      end else if (start) begin
         frame_q <= 1'b1;
         done_q <= 1'b0;
         bit_q <= 4'h0;
         byte_q <= 8'h00;
      end else if (stop) begin
         frame_q <= 1'b0;
      end else if (rise) begin
         sh_q <= {sh_q[6:0], sda};
         bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
         if (bit_q == 4'h8)
            byte_q <= byte_q + 8'h01;
         if (bit_q == 4'h7 && byte_q == 8'h00)
            addr_q <= {sh_q[6:0], sda};
         if (bit_q == 4'h8 && byte_q != 8'h00 && addr_q[0] && sda)
            done_q <= 1'b1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_hold_stable; scl && scl_q |-> $stable(t_sda_oe); endproperty
   a_hold_stable: assert property (p_hold_stable) else $error("data moved, clock high");
   property p_idle_release; !frame_q |-> !t_sda_oe; endproperty
   a_idle_release: assert property (p_idle_release) else $error("data held when idle");
   property p_addr_quiet; frame_q && byte_q == 8'h00 && bit_q < 4'h8 |-> !t_sda_oe; endproperty
   a_addr_quiet: assert property (p_addr_quiet) else $error("data held in address");
   property p_foreign; frame_q && past_addr && foreign |-> !t_sda_oe; endproperty
   a_foreign: assert property (p_foreign) else $error("answered other address");
   property p_gc_ack;
      rise && bit_q == 4'h8 && byte_q == 8'h00 && addr_q == GC_BYTE |-> t_sda_oe;
   endproperty
   a_gc_ack: assert property (p_gc_ack) else $error("general call not acknowledged");
   property p_read_done; done_q |-> !t_sda_oe; endproperty
   a_read_done: assert property (p_read_done) else $error("sent after final nack");
   property p_timeout; low_q <= TIMEOUT_CYCLES + 16; endproperty
   a_timeout: assert property (p_timeout) else $error("data held past timeout");
   property p_pull_low; $rose(t_sda_oe) |-> !scl; endproperty
   a_pull_low: assert property (p_pull_low) else $error("data pulled, clock high");
   cover property (rise && bit_q == 4'h8 && byte_q == 8'h00 && t_sda_oe);
   cover property (rise && bit_q == 4'h8 && byte_q == 8'h00 && !t_sda_oe);
   cover property (done_q && stop);
endmodule
`default_nettype wire

// file: tb/tb_sensor_two_wire_target_port.sv
// Testbench joining the bus controller to the sensor target
`timescale 1ns/1ps
`default_nettype none
module tb_sensor_two_wire_target_port;
   import tst_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, pin, wr_en, alert_clear, soft_reset, reloading;
   logic rl_ok = 1'b0;
   logic [1:0] strap = 2'h0;
   logic [15:0] rd_data = 16'h0;
   logic [15:0] wr_data;
   logic [7:0] register_index;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   int n_soft = 0;
   int n_wr = 0;
   int n_clr = 0;
   logic alert_on = 1'b0, alert_hi = 1'b0, thr = 1'b0;
   logic [15:0] wr_seen = 16'h0;
   int rl_win = 0;
   tst_link_if tst_link_if_i ();
   always #2 hclk = ~hclk;
   assign pin = strap[1] ? (strap[0] ? tst_link_if_i.scl : tst_link_if_i.sda) : strap[0];
   tst_controller #(.QTR_CYCLES(8)) tst_controller_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .link(tst_link_if_i.ctrl));
   tst_target #(.TIMEOUT_CYCLES(2000), .RELOAD_CYCLES(50)) tst_target_i (.hclk(hclk),
      .hresetn(hresetn), .link(tst_link_if_i.tgt), .address_select_pin(pin),
      .alert_active(alert_on), .alert_high(alert_hi), .threshold_or_window_select(thr),
      .rd_data(rd_data), .register_index(register_index), .wr_en(wr_en), .wr_data(wr_data),
      .alert_clear(alert_clear), .soft_reset(soft_reset), .reloading(reloading));
   tst_link_props #(.TIMEOUT_CYCLES(2000)) tst_link_props_i (.hclk(hclk), .hresetn(hresetn),
      .m_scl_oe(tst_link_if_i.m_scl_oe), .m_sda_oe(tst_link_if_i.m_sda_oe),
      .t_sda_oe(tst_link_if_i.t_sda_oe), .scl(tst_link_if_i.scl), .sda(tst_link_if_i.sda));
   // Pulse counters and hang guard
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (soft_reset === 1'b1)
         n_soft <= n_soft + 1;
      n_wr <= n_wr + 32'(wr_en === 1'b1);
      n_clr <= n_clr + 32'(alert_clear === 1'b1);
      if (wr_en === 1'b1)
         wr_seen <= wr_data;
      rl_win <= (soft_reset === 1'b1) ? 4 : (rl_win > 0 ? rl_win - 1 : 0);
      if (rl_win > 0 && reloading === 1'b1)
         rl_ok <= 1'b1;
      if (cyc == 80000) begin
         n_errors = n_errors + 1;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // One frame; returns status and received bytes
   task automatic xfer(input logic [7:0] ab, input logic [2:0] nb, input logic [31:0] tx,
         output logic [31:0] st, output logic [31:0] rx);
      int i;
      ahb(1'b1, TXD_OFS, tx, st);
      ahb(1'b1, CTRL_OFS, {21'h0, nb, ab}, st);
      repeat (4) @(posedge hclk);
      i = 0;
      do begin
         ahb(1'b0, STAT_OFS, 32'h0, st);
         i++;
      end while (st[STAT_BUSY_BIT] !== 1'b0 && i < 4000);
      ahb(1'b0, RXD_OFS, 32'h0, rx);
   endtask
   task automatic t_reset();
      logic [31:0] rd;
      chk("index", {24'h0, INDEX_RESET}, {24'h0, register_index});
      @(posedge hclk);
      chk("reload on", 32'h1, {31'h0, reloading});
      repeat (60) @(posedge hclk);
      chk("reload off", 32'h0, {31'h0, reloading});
      ahb(1'b0, STAT_OFS, 32'h0, rd);
      chk("stat", REG_RESET, rd);
      ahb(1'b0, 8'h10, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   task automatic t_strap_reads();
      logic [31:0] st, rx;
      logic [15:0] w;
      for (int s = 0; s < 4; s++) begin
         w = 16'ha53c ^ 16'(s);
         // Strap decode flags stick until reset and settle during the first frame
         hresetn <= 1'b0;
         strap <= s[1:0];
         rd_data <= w;
         repeat (2) @(posedge hclk);
         hresetn <= 1'b1;
         @(posedge hclk);
         xfer({ADDR_HI, s[1:0], 1'b1}, 3'h1, 32'h0, st, rx);
         xfer({ADDR_HI, s[1:0], 1'b1}, 3'h1, 32'h0, st, rx);
         chk("ack one", 32'h0, {30'h0, st[1:0]});
         chk("msb only", {24'h0, w[15:8]}, rx & 32'hff);
         xfer({ADDR_HI, s[1:0], 1'b1}, 3'h2, 32'h0, st, rx);
         chk("word", {16'h0, w}, rx & 32'hffff);
         xfer({ADDR_HI, s[1:0] + 2'h1, 1'b1}, 3'h1, 32'h0, st, rx);
         chk("other strap", 32'h2, {30'h0, st[1:0]});
      end
   endtask
   task automatic t_long_read();
      logic [31:0] st, rx;
      rd_data <= 16'h9e71;
      xfer({ADDR_HI, 2'h3, 1'b1}, 3'h3, 32'h0, st, rx);
      chk("three bytes", 32'h009e719e, rx & 32'hffffff);
      chk("index kept", 32'h0, {24'h0, register_index});
   endtask
   task automatic t_foreign();
      logic [31:0] st, rx;
      logic [7:0] tbl [3] = '{8'h01, 8'h19, 8'hb1};
      foreach (tbl[k]) begin
         xfer(tbl[k], 3'h0, 32'h0, st, rx);
         chk("no ack", 32'h2, {30'h0, st[1:0]});
      end
   endtask
   task automatic t_gc();
      logic [31:0] st, rx;
      xfer(GC_BYTE, 3'h1, {GC_RESET_CMD, 24'h0}, st, rx);
      chk("gc ack", 32'h0, {30'h0, st[1:0]});
      chk("soft reset", 32'h1, 32'(n_soft));
      chk("reload again", 32'h1, {31'h0, rl_ok});
      repeat (60) @(posedge hclk);
      xfer(GC_BYTE, 3'h1, {8'h07, 24'h0}, st, rx);
      chk("gc other", 32'h2, {30'h0, st[1:0]});
      chk("no reset", 32'h1, 32'(n_soft));
   endtask
   task automatic t_write();
      logic [31:0] st, rx;
      xfer({ADDR_HI, 2'h3, 1'b0}, 3'h4, 32'h05c35a77, st, rx);
      chk("write ack", 32'h0, st & 32'h3);
      chk("index load", 32'h5, 32'(register_index));
      chk("word data", 32'h1c35a, {16'(n_wr), wr_seen});
      xfer({ADDR_HI, 2'h3, 1'b0}, 3'h1, 32'h0, st, rx);
      chk("index only", 32'h100, {24'(n_wr), register_index});
   endtask
   task automatic t_alert();
      logic [31:0] st, rx;
      alert_on <= 1'b1;
      alert_hi <= 1'b1;
      xfer(ARA_BYTE, 3'h1, 32'h0, st, rx);
      chk("alert ack", 32'h0, st & 32'h3);
      chk("alert high", {24'h1, ADDR_HI, 2'h3, 1'b1}, {24'(n_clr), rx[7:0]});
      thr <= 1'b1;
      alert_hi <= 1'b0;
      xfer(ARA_BYTE, 3'h1, 32'h0, st, rx);
      chk("alert low", {24'h1, ADDR_HI, 2'h3, 1'b0}, {24'(n_clr), rx[7:0]});
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_strap_reads();
      t_long_read();
      t_foreign();
      t_gc();
      t_write();
      t_alert();
      chk("strobes", 32'h2, 32'(n_wr + n_clr));
      print_verdict();
   end
endmodule
`default_nettype wire
